//--- shared/oofc_pkg.sv
// constants and state types for the oscillator offset control block
// assumes a byte-wide register port fed by a serial-bus slave
package oofc_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_INC_DIS = 8'h06;
    localparam logic [7:0] ADDR_SYNC    = 8'h1A;
    localparam logic [7:0] ADDR_SHIFT   = 8'h1B;
    localparam logic [7:0] ADDR_CTRL    = 8'h1C;
    localparam logic [7:0] ADDR_DATA_H  = 8'h1D;
    localparam logic [7:0] ADDR_DATA_MH = 8'h1E;
    localparam logic [7:0] ADDR_DATA_ML = 8'h1F;
    localparam logic [7:0] ADDR_DATA_L  = 8'h20;
    localparam logic [7:0] ADDR_BW      = 8'h41;
    localparam logic [7:0] ADDR_LIMIT   = 8'h42;
    localparam logic [7:0] ADDR_OUTDIS  = 8'h43;

    // field positions
    localparam int CTRL_SIZE_LSB   = 0;
    localparam int CTRL_STREAM_BIT = 4;
    localparam int CTRL_REL_BIT    = 5;
    localparam int CTRL_ENA_BIT    = 6;
    localparam int CTRL_CLR_BIT    = 7;
    localparam int SYNC_RESYNC_BIT = 0;
    localparam int SYNC_CLR_BIT    = 1;
    localparam int SYNC_NEG_BIT    = 6;
    localparam int SYNC_POS_BIT    = 7;
    localparam int LIMIT_SHIFT     = 13;

    // limits and reset values
    localparam logic [4:0] SHIFT_MAX = 5'h18;
    localparam logic [2:0] SIZE_MAX  = 3'h4;
    localparam logic [2:0] RST_BW    = 3'h7;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [4:0] RST_SHIFT = 5'h00;

    typedef struct packed {
        logic        req_s1;
        logic        req_s2;
        logic        req_prev;
        logic        ack_tgl;
        logic [7:0]  rdata;
        logic        inc_dis;
        logic [4:0]  shift;
        logic [2:0]  size;
        logic        stream;
        logic        rel;
        logic        ena;
        logic [23:0] hold;
        logic [23:0] asm_bytes;
        logic [1:0]  cnt;
        logic [31:0] offset;
        logic        sat_neg;
        logic        sat_pos;
        logic [2:0]  bw;
        logic [7:0]  limit;
        logic        force0;
        logic [21:0] out;
    } oofc_sys_t;

    typedef struct packed {
        logic       idle;
        logic       req_tgl;
        logic       ack_s1;
        logic       ack_s2;
        logic       ack_seen;
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       rvalid;
        logic [7:0] rdata;
    } oofc_link_t;

endpackage

//--- logic/oofc_top.sv
// offset control register bank, value assembly and offset datapath
// assumes a bus slave on link_clk presenting one byte access at a time
// and a low-pass filter on clk_sys returning its 22-bit result
//
// Notes on behaviour
// - shift amounts above 24 act as exactly 24
// - byte count code 0 or above 4 acts as 4 bytes
// - assembled value sign-extended to 57 bits, then left shifted
// - stream bursts arrive most significant byte first, low byte last
// - direct mode takes bottom N bytes, byte at +3 least significant
// - upper data bytes held; value processed only on low byte write
// - in stream mode only low byte location accepts data
// - master disables auto-increment before streaming; setting is global
// - absolute mode saturates shifted value to 32 bits as new offset
// - relative mode adds to offset in 57 bits then saturates
// - saturation flags updated on every internal offset update
// - enable low stops processing; only clear bit still acts
// - clear resets offset, holding and stream sync, not shift
// - any control write resets stream synchronisation
// - data byte reads return current internal 32-bit offset
// - offset is signed 11.21 fixed point, larger means faster
// - data register big-endian at 0x1d, low byte at highest address
// - bandwidth code 0..6 filters, code 7 bypasses and is reset
// - filtered output clamped to plus or minus limit shifted by 13
// - output disable forces output zero, datapath keeps running
// - resync bit restarts burst at next low byte write
// - secondary clear bit acts exactly like the control clear
// - negative and positive flags at sync bits 6 and 7
module oofc_top #(
    parameter int EXT_W = 57
) (
    input  logic        clk_sys,
    input  logic        sys_rst,
    input  logic        link_clk,
    input  logic        link_rst,
    input  logic        bus_valid,
    input  logic        bus_write,
    input  logic [7:0]  bus_addr,
    input  logic [7:0]  bus_wdata,
    output logic        bus_ready,
    output logic        bus_rvalid,
    output logic [7:0]  bus_rdata,
    input  logic [21:0] filtered_in,
    output logic [21:0] freq_ctrl,
    output logic [31:0] offset_value,
    output logic [2:0]  filter_bandwidth_code,
    output logic [7:0]  absolute_limit_value,
    output logic        force_output_zero,
    output logic        autoincrement_disable
);

    initial begin
        if (EXT_W < 57) begin
            $error("EXT_W must hold 32 bits shifted by 24 plus sign");
        end
    end

    localparam oofc_pkg::oofc_sys_t SYS_RST = '{
        bw: oofc_pkg::RST_BW, limit: oofc_pkg::RST_LIMIT,
        shift: oofc_pkg::RST_SHIFT, default: '0};
    localparam oofc_pkg::oofc_link_t LINK_RST = '{idle: 1'b1, default: '0};

    oofc_pkg::oofc_sys_t  s_r;
    oofc_pkg::oofc_sys_t  s_nxt;
    oofc_pkg::oofc_link_t l_r;
    oofc_pkg::oofc_link_t l_nxt;

    ////////////////////////////////////////////////////////////////////////
    // link side: one access in flight, toggle handshake to clk_sys

    always_comb begin
        l_nxt        = l_r;
        l_nxt.ack_s1 = s_r.ack_tgl;
        l_nxt.ack_s2 = l_r.ack_s1;
        l_nxt.rvalid = 1'b0;
        if (!l_r.idle && (l_r.ack_s2 != l_r.ack_seen)) begin
            l_nxt.ack_seen = l_r.ack_s2;
            l_nxt.idle     = 1'b1;
            if (!l_r.we) begin
                l_nxt.rvalid = 1'b1;
                l_nxt.rdata  = s_r.rdata;
            end
        end else if (l_r.idle && bus_valid) begin
            l_nxt.addr    = bus_addr;
            l_nxt.wdata   = bus_wdata;
            l_nxt.we      = bus_write;
            l_nxt.req_tgl = ~l_r.req_tgl;
            l_nxt.idle    = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_r <= LINK_RST;
        end else begin
            l_r <= l_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system side decode and datapath

    logic              acc;
    logic              acc_wr;
    logic [2:0]        size_eff;
    logic [4:0]        shift_eff;
    logic              low_wr;
    logic              complete;
    logic              proc_go;
    logic [31:0]       word;
    logic [EXT_W-1:0]  ext;
    logic [EXT_W-1:0]  shifted;
    logic [EXT_W-1:0]  sum;
    logic [EXT_W-32:0] sum_hi;
    logic              no_sat;
    logic [21:0]       lim_p;
    logic [21:0]       lim_n;
    logic              clr_req;

    assign acc    = s_r.req_s2 ^ s_r.req_prev;
    assign acc_wr = acc && l_r.we;
    assign size_eff = (s_r.size == 3'h0 || s_r.size > oofc_pkg::SIZE_MAX)
                    ? oofc_pkg::SIZE_MAX : s_r.size;
    assign shift_eff = (s_r.shift > oofc_pkg::SHIFT_MAX)
                     ? oofc_pkg::SHIFT_MAX : s_r.shift;
    assign low_wr   = acc_wr && l_r.addr == oofc_pkg::ADDR_DATA_L;
    assign complete = !s_r.stream
                   || ({1'b0, s_r.cnt} == 3'(size_eff - 3'h1));
    assign proc_go  = low_wr && s_r.ena && complete;
    // stream bytes enter at the bottom, so the low byte is always last
    assign word = s_r.stream ? {s_r.asm_bytes, l_r.wdata}
                             : {s_r.hold, l_r.wdata};

    always_comb begin
        case (size_eff)
            3'h1:    ext = {{(EXT_W-8){word[7]}}, word[7:0]};
            3'h2:    ext = {{(EXT_W-16){word[15]}}, word[15:0]};
            3'h3:    ext = {{(EXT_W-24){word[23]}}, word[23:0]};
            default: ext = {{(EXT_W-32){word[31]}}, word};
        endcase
    end

    assign shifted = ext << shift_eff;
    assign sum = s_r.rel
               ? shifted + {{(EXT_W-32){s_r.offset[31]}}, s_r.offset}
               : shifted;
    assign sum_hi  = sum[EXT_W-1:31];
    assign no_sat  = (&sum_hi) || !(|sum_hi);
    assign lim_p   = 22'({s_r.limit, 13'h0000});
    assign lim_n   = 22'(-$signed(lim_p));
    assign clr_req = acc_wr
        && ((l_r.addr == oofc_pkg::ADDR_CTRL
             && l_r.wdata[oofc_pkg::CTRL_CLR_BIT])
         || (l_r.addr == oofc_pkg::ADDR_SYNC
             && l_r.wdata[oofc_pkg::SYNC_CLR_BIT]));

    always_comb begin
        s_nxt          = s_r;
        s_nxt.req_s1   = l_r.req_tgl;
        s_nxt.req_s2   = s_r.req_s1;
        s_nxt.req_prev = s_r.req_s2;
        if (acc) begin
            s_nxt.ack_tgl = ~s_r.ack_tgl;
            case (l_r.addr)
                oofc_pkg::ADDR_INC_DIS: s_nxt.rdata = {7'h00, s_r.inc_dis};
                oofc_pkg::ADDR_SYNC:
                    s_nxt.rdata = {s_r.sat_pos, s_r.sat_neg, 6'h00};
                oofc_pkg::ADDR_SHIFT:   s_nxt.rdata = {3'h0, s_r.shift};
                oofc_pkg::ADDR_CTRL:
                    s_nxt.rdata = {1'b0, s_r.ena, s_r.rel, s_r.stream,
                                   1'b0, s_r.size};
                oofc_pkg::ADDR_DATA_H:  s_nxt.rdata = s_r.offset[31:24];
                oofc_pkg::ADDR_DATA_MH: s_nxt.rdata = s_r.offset[23:16];
                oofc_pkg::ADDR_DATA_ML: s_nxt.rdata = s_r.offset[15:8];
                oofc_pkg::ADDR_DATA_L:  s_nxt.rdata = s_r.offset[7:0];
                oofc_pkg::ADDR_BW:      s_nxt.rdata = {5'h00, s_r.bw};
                oofc_pkg::ADDR_LIMIT:   s_nxt.rdata = s_r.limit;
                oofc_pkg::ADDR_OUTDIS:  s_nxt.rdata = {7'h00, s_r.force0};
                default:                s_nxt.rdata = 8'h00;
            endcase
        end
        if (acc_wr) begin
            case (l_r.addr)
                oofc_pkg::ADDR_INC_DIS: s_nxt.inc_dis = l_r.wdata[0];
                oofc_pkg::ADDR_SYNC: begin
                    if (l_r.wdata[oofc_pkg::SYNC_RESYNC_BIT]) begin
                        s_nxt.cnt = 2'h0;
                    end
                end
                oofc_pkg::ADDR_SHIFT: s_nxt.shift = l_r.wdata[4:0];
                oofc_pkg::ADDR_CTRL: begin
                    s_nxt.size   = l_r.wdata[oofc_pkg::CTRL_SIZE_LSB +: 3];
                    s_nxt.stream = l_r.wdata[oofc_pkg::CTRL_STREAM_BIT];
                    s_nxt.rel    = l_r.wdata[oofc_pkg::CTRL_REL_BIT];
                    s_nxt.ena    = l_r.wdata[oofc_pkg::CTRL_ENA_BIT];
                    s_nxt.cnt    = 2'h0;
                end
                oofc_pkg::ADDR_DATA_H: begin
                    if (!s_r.stream) begin
                        s_nxt.hold[23:16] = l_r.wdata;
                    end
                end
                oofc_pkg::ADDR_DATA_MH: begin
                    if (!s_r.stream) begin
                        s_nxt.hold[15:8] = l_r.wdata;
                    end
                end
                oofc_pkg::ADDR_DATA_ML: begin
                    if (!s_r.stream) begin
                        s_nxt.hold[7:0] = l_r.wdata;
                    end
                end
                oofc_pkg::ADDR_DATA_L: begin
                    if (s_r.ena && s_r.stream) begin
                        s_nxt.asm_bytes = {s_r.asm_bytes[15:0], l_r.wdata};
                        s_nxt.cnt = complete ? 2'h0 : s_r.cnt + 2'h1;
                    end
                end
                oofc_pkg::ADDR_BW:     s_nxt.bw = l_r.wdata[2:0];
                oofc_pkg::ADDR_LIMIT:  s_nxt.limit = l_r.wdata;
                oofc_pkg::ADDR_OUTDIS: s_nxt.force0 = l_r.wdata[0];
                default: ;
            endcase
        end
        if (proc_go) begin
            s_nxt.sat_pos = !no_sat && !sum[EXT_W-1];
            s_nxt.sat_neg = !no_sat && sum[EXT_W-1];
            if (no_sat) begin
                s_nxt.offset = sum[31:0];
            end else if (sum[EXT_W-1]) begin
                s_nxt.offset = 32'h8000_0000;
            end else begin
                s_nxt.offset = 32'h7FFF_FFFF;
            end
        end
        if (clr_req) begin
            s_nxt.offset    = 32'h0000_0000;
            s_nxt.hold      = 24'h00_0000;
            s_nxt.asm_bytes = 24'h00_0000;
            s_nxt.cnt       = 2'h0;
            s_nxt.sat_pos   = 1'b0;
            s_nxt.sat_neg   = 1'b0;
        end
        if (s_r.force0) begin
            s_nxt.out = 22'h00_0000;
        end else if ($signed(filtered_in) > $signed(lim_p)) begin
            s_nxt.out = lim_p;
        end else if ($signed(filtered_in) < $signed(lim_n)) begin
            s_nxt.out = lim_n;
        end else begin
            s_nxt.out = filtered_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_r <= SYS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_ready             = l_r.idle;
    assign bus_rvalid            = l_r.rvalid;
    assign bus_rdata             = l_r.rdata;
    assign freq_ctrl             = s_r.out;
    assign offset_value          = s_r.offset;
    assign filter_bandwidth_code = s_r.bw;
    assign absolute_limit_value  = s_r.limit;
    assign force_output_zero     = s_r.force0;
    assign autoincrement_disable = s_r.inc_dis;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    AST_SHIFT_CLAMP: assert property (
        (s_r.shift > 5'h18) |-> (shift_eff == 5'h18))
        else $error("shift not clamped to 24");

    AST_SIZE_MAP: assert property (
        (s_r.size == 3'h0 || s_r.size > 3'h4) |-> (size_eff == 3'h4))
        else $error("byte count not forced to 4");

    AST_CLEAR: assert property (
        clr_req |=> (s_r.offset == 32'h0 && s_r.cnt == 2'h0
                     && !s_r.sat_pos && !s_r.sat_neg && s_r.hold == 24'h0))
        else $error("clear left state behind");

    AST_CTRL_RESYNC: assert property (
        (acc_wr && l_r.addr == 8'h1C) |=> (s_r.cnt == 2'h0))
        else $error("control write did not resync stream");

    AST_STREAM_IGNORE: assert property (
        (acc_wr && s_r.stream && l_r.addr != 8'h20 && l_r.addr >= 8'h1D
         && l_r.addr <= 8'h1F) |=> $stable(s_r.hold))
        else $error("upper data byte taken in stream mode");

    AST_ABS_LOAD: assert property (
        (proc_go && !s_r.rel && no_sat && !clr_req)
        |=> (s_r.offset == $past(shifted[31:0])))
        else $error("absolute value not loaded");

    AST_SAT_FLAGS: assert property (
        (proc_go && !clr_req) |=> (s_r.sat_pos == ($past(!no_sat)
            && !$past(sum[EXT_W-1])) && !(s_r.sat_pos && s_r.sat_neg)))
        else $error("saturation flag wrong");

    AST_DISABLED_HOLD: assert property (
        (!s_r.ena && !clr_req) |=> $stable(s_r.offset))
        else $error("offset changed while disabled");

    AST_READ_OFFSET: assert property (
        (acc && !l_r.we && l_r.addr == 8'h20)
        |=> (s_r.rdata == $past(s_r.offset[7:0])))
        else $error("low byte read is not the offset");

    AST_FORCE_ZERO: assert property (
        s_r.force0 |=> (s_r.out == 22'h0))
        else $error("output not forced to zero");

    AST_LIMIT: assert property (
        !$past(s_r.force0) |-> ($signed(s_r.out) <= $signed($past(lim_p))
            && $signed(s_r.out) >= $signed($past(lim_n))))
        else $error("output outside limit");

    AST_OFFSET_STEADY: assert property (
        (!proc_go && !clr_req) |=> $stable(s_r.offset))
        else $error("offset changed without a value write");

    AST_REL_LOAD: assert property (
        (proc_go && s_r.rel && no_sat && !clr_req)
        |=> (s_r.offset == $past(s_r.offset) + $past(shifted[31:0])))
        else $error("relative step not added");

    AST_SAT_VALUE: assert property (
        (proc_go && !no_sat && !clr_req)
        |=> (s_r.offset == ($past(sum[EXT_W-1]) ? 32'h8000_0000
                                                : 32'h7FFF_FFFF)))
        else $error("saturated offset not at the rail");

    AST_NEG_FLAG: assert property (
        (proc_go && !clr_req) |=> (s_r.sat_neg == ($past(!no_sat)
            && $past(sum[EXT_W-1]))))
        else $error("negative saturation flag wrong");

    AST_RESYNC: assert property (
        (acc_wr && l_r.addr == oofc_pkg::ADDR_SYNC
         && l_r.wdata[oofc_pkg::SYNC_RESYNC_BIT]) |=> (s_r.cnt == 2'h0))
        else $error("resync did not restart the burst");

    AST_SHIFT_KEPT: assert property (
        clr_req |=> $stable(s_r.shift))
        else $error("clear changed the shift setting");

    AST_BURST_COUNT: assert property (
        (low_wr && s_r.ena && s_r.stream && !complete && !clr_req)
        |=> (s_r.cnt == $past(s_r.cnt) + 2'h1))
        else $error("stream byte not counted");

    AST_OUT_PASS: assert property (
        (!s_r.force0 && $signed(filtered_in) <= $signed(lim_p)
         && $signed(filtered_in) >= $signed(lim_n))
        |=> (s_r.out == $past(filtered_in)))
        else $error("in-range value not passed through");

    COV_STREAM_VALUE: cover property (proc_go && s_r.stream
                                      && size_eff == 3'h2);
    COV_REL_SAT: cover property (proc_go && s_r.rel && !no_sat);
    COV_DIRECT_VALUE: cover property (proc_go && !s_r.stream);
    COV_CLEAR: cover property (clr_req && !s_r.ena);
    COV_RESYNC: cover property (acc_wr && l_r.addr == oofc_pkg::ADDR_SYNC);

endmodule

//--- verif/oofc_bus_model.sv
// bus master model issuing single byte accesses on the register port
// assumes the link_clk valid/ready handshake of the block's register port
module oofc_bus_model (
    input  logic       link_clk,
    input  logic       bus_ready,
    input  logic       bus_rvalid,
    input  logic [7:0] bus_rdata,
    output logic       bus_valid,
    output logic       bus_write,
    output logic [7:0] bus_addr,
    output logic [7:0] bus_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        bus_valid = 1'b0;
        bus_write = 1'b0;
        bus_addr  = 8'h00;
        bus_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // one access: held for one link_clk rising edge without checking ready, then released with scrambled lines
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge link_clk);
        bus_valid = 1'b1;
        bus_write = w;
        bus_addr  = a;
        bus_wdata = d;
        @(posedge link_clk);
        @(negedge link_clk);
        bus_valid = 1'b0;
        bus_write = ~w;
        bus_addr  = ~a;
        bus_wdata = ~d;
        do begin
            @(negedge link_clk);
            if (bus_rvalid === 1'b1)
                rd = bus_rdata;
        end while (bus_ready !== 1'b1);
    endtask
endmodule

//--- verif/oofc_top_tb.sv
// self-checking bench for the offset control block
// assumes oofc_pkg, oofc_top and the bus master model are compiled first
module oofc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys;
    logic        sys_rst;
    logic        link_clk;
    logic        link_rst;
    logic        bus_valid;
    logic        bus_write;
    logic [7:0]  bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_ready;
    logic        bus_rvalid;
    logic [7:0]  bus_rdata;
    logic [21:0] filtered_in;
    logic [21:0] freq_ctrl;
    logic [31:0] offset_value;
    logic [2:0]  filter_bandwidth_code;
    logic [7:0]  absolute_limit_value;
    logic        force_output_zero;
    logic        autoincrement_disable;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;

    oofc_top dut_u (
        .clk_sys, .sys_rst, .link_clk, .link_rst, .bus_valid, .bus_write,
        .bus_addr, .bus_wdata, .bus_ready, .bus_rvalid, .bus_rdata,
        .filtered_in, .freq_ctrl, .offset_value, .filter_bandwidth_code,
        .absolute_limit_value, .force_output_zero, .autoincrement_disable
    );

    oofc_bus_model mdl_u (
        .link_clk, .bus_ready, .bus_rvalid, .bus_rdata,
        .bus_valid, .bus_write, .bus_addr, .bus_wdata
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #62.5 link_clk = ~link_clk;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        mdl_u.acc(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        mdl_u.acc(1'b0, a, 8'h00, v);
    endtask

    task automatic wdat(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            wr(8'h1D + 8'(i), v[31-8*i -: 8]);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] b;
        rd(a, b);
        chk({24'h0, b}, {24'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [7:0] ad [8] = '{8'h06, 8'h1A, 8'h1B, 8'h1C,
                               8'h1D, 8'h41, 8'h42, 8'h43};
        logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h07, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
            rchk(ad[i], ex[i]);
        chk({29'h0, filter_bandwidth_code}, 32'h7);
        chk({10'h0, freq_ctrl}, 32'h0);
        wr(8'h50, 8'hA5);
        rchk(8'h50, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_direct();
        logic [31:0] v;
        logic [7:0]  b;
        logic [7:0]  ct [6] = '{8'hC1, 8'hC1, 8'hC2, 8'hC7, 8'hC7, 8'hC0};
        logic [7:0]  sh [6] = '{8'h1F, 8'h18, 8'h00, 8'h00, 8'h08, 8'h04};
        logic [31:0] dv [6] = '{32'h1, 32'h80, 32'hAAAA8001, 32'h80000001,
                                32'hFF000000, 32'h08000000};
        logic [31:0] ex [6] = '{32'h01000000, 32'h80000000, 32'hFFFF8001,
                                32'h80000001, 32'h80000000, 32'h7FFFFFFF};
        logic [7:0]  fl [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h80};
        wr(8'h1C, 8'hC0);
        wr(8'h1D, 8'h12);
        wr(8'h1E, 8'h34);
        wr(8'h1F, 8'h56);
        chk(offset_value, 32'h0);
        wr(8'h20, 8'h78);
        chk(offset_value, 32'h12345678);
        v = 32'h0;
        for (int i = 0; i < 4; i++) begin
            rd(8'h1D + 8'(i), b);
            v = {v[23:0], b};
        end
        chk(v, 32'h12345678);
        rchk(8'h1C, 8'h40);
        for (int i = 0; i < 6; i++) begin
            wr(8'h1C, ct[i]);
            wr(8'h1B, sh[i]);
            wdat(dv[i]);
            chk(offset_value, ex[i]);
            rchk(8'h1A, fl[i]);
        end
        $display("direct test done");
    endtask

    task automatic t_rel();
        wr(8'h1C, 8'hE4);
        wr(8'h1B, 8'h00);
        wdat(32'h00000010);
        wdat(32'h00000020);
        chk(offset_value, 32'h30);
        wdat(32'h7FFFFFF0);
        chk(offset_value, 32'h7FFFFFFF);
        rchk(8'h1A, 8'h80);
        wdat(32'hFFFFFFFF);
        chk(offset_value, 32'h7FFFFFFE);
        rchk(8'h1A, 8'h00);
        wr(8'h1B, 8'h03);
        wr(8'h1A, 8'h02);
        chk(offset_value, 32'h0);
        rchk(8'h1B, 8'h03);
        wr(8'h20, 8'h05);
        chk(offset_value, 32'h28);
        $display("relative test done");
    endtask

    task automatic t_off();
        wr(8'h1C, 8'hC0);
        wr(8'h1B, 8'h00);
        wdat(32'h00000055);
        wr(8'h1C, 8'h20);
        wdat(32'h00000077);
        chk(offset_value, 32'h55);
        wr(8'h1C, 8'h80);
        chk(offset_value, 32'h0);
        $display("disabled test done");
    endtask

    task automatic t_stream();
        wr(8'h06, 8'h01);
        chk({31'h0, autoincrement_disable}, 32'h1);
        wr(8'h1C, 8'hD2);
        wr(8'h1D, 8'h7F);
        wr(8'h20, 8'h12);
        chk(offset_value, 32'h0);
        wr(8'h20, 8'h34);
        chk(offset_value, 32'h1234);
        wr(8'h20, 8'hAB);
        wr(8'h1A, 8'h01);
        wr(8'h20, 8'hFF);
        wr(8'h20, 8'hFE);
        chk(offset_value, 32'hFFFFFFFE);
        wr(8'h20, 8'h01);
        wr(8'h1C, 8'h52);
        wr(8'h20, 8'h00);
        wr(8'h20, 8'h07);
        chk(offset_value, 32'h7);
        rchk(8'h20, 8'h07);
        wr(8'h06, 8'h00);
        $display("stream test done");
    endtask

    task automatic t_out();
        logic [7:0]  lm [4] = '{8'h01, 8'h01, 8'hFF, 8'h00};
        logic [21:0] fi [4] = '{22'h004E20, 22'h3FB1E0, 22'h004E20, 22'h4E20};
        logic [21:0] fe [4] = '{22'h002000, 22'h3FE000, 22'h004E20, 22'h0};
        for (int i = 0; i < 4; i++) begin
            wr(8'h42, lm[i]);
            chk({24'h0, absolute_limit_value}, {24'h0, lm[i]});
            @(negedge clk_sys);
            filtered_in = fi[i];
            repeat (3) @(negedge clk_sys);
            chk({10'h0, freq_ctrl}, {10'h0, fe[i]});
        end
        wr(8'h42, 8'hFF);
        wr(8'h43, 8'h01);
        chk({31'h0, force_output_zero}, 32'h1);
        repeat (3) @(negedge clk_sys);
        chk({10'h0, freq_ctrl}, 32'h0);
        chk(offset_value, 32'h7);
        wr(8'h41, 8'h03);
        chk({29'h0, filter_bandwidth_code}, 32'h3);
        wr(8'h43, 8'h00);
        repeat (3) @(negedge clk_sys);
        chk({10'h0, freq_ctrl}, 32'h4E20);
        $display("output test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        sys_rst     = 1'b1;
        link_rst    = 1'b1;
        filtered_in = 22'h000000;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge link_clk);
        link_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_direct();
        t_rel();
        t_off();
        t_stream();
        t_out();
        end_sim();
    end
endmodule
